// ==== src/pss_cfg.svh ====
/*
  Timing counts, field positions and reset values for the program step sequencer.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

`define PSS_CLK_HZ 50000000
`define PSS_WAIT_MS_UNIT 1
`define PSS_CYC_PER_MS ((`PSS_CLK_HZ / 1000) * `PSS_WAIT_MS_UNIT)
`define PSS_WIDTH_MIN 27'h0000001
`define PSS_WIDTH_MAX 27'h5f5e0ff
`define PSS_WIDTH_RST 27'h000000a
`define PSS_POS_MAX 32'h05f5e0ff
`define PSS_POS_MIN 32'hfa0a1f01
`define PSS_AREA_RST 32'h00000000
`define PSS_WAIT_MAX 17'h1869f
`define PSS_STEP_MAX 6'h3f

`define PSS_ADDR_CTRL 12'h000
`define PSS_ADDR_STATUS 12'h004
`define PSS_ADDR_GWIDTH 12'h008
`define PSS_ADDR_TSEL 12'h00c
`define PSS_ADDR_TWIDTH 12'h010
`define PSS_ADDR_TAREA1 12'h014
`define PSS_ADDR_TAREA2 12'h018
`define PSS_ADDR_TEVENT 12'h01c
`define PSS_ADDR_TNEXT 12'h020
`define PSS_ADDR_POS 12'h024

`define PSS_EV_COND_LSB 17
`define PSS_EV_SAME_BIT 20
`define PSS_NX_END_BIT 6
`define PSS_WD_SRC_LSB 27

`endif

// ==== src/pss_mem_if.sv ====
/*
  Carrier between the sequencer and its step table.
  Assumes one clock shared by both ends.
*/
`default_nettype none
interface pss_mem_if;
  logic we;
  logic [5:0] waddr;
  logic [2:0] wsel;
  logic [31:0] wdata;
  logic [5:0] raddr;
  logic [31:0] rwidth;
  logic [31:0] rarea1;
  logic [31:0] rarea2;
  logic [31:0] revent;
  logic [31:0] rnext;
  modport ctl (output we, waddr, wsel, wdata, raddr, input rwidth, rarea1, rarea2, revent, rnext);
  modport mem (input we, waddr, wsel, wdata, raddr, output rwidth, rarea1, rarea2, revent, rnext);
endinterface
`default_nettype wire

// ==== src/pss_pkg.sv ====
/*
  Types of the program step sequencer.
  Assumes the config header is on the include path.
*/
`default_nettype none
package pss_pkg;
  typedef enum logic [2:0] {
    COND_IN_POS,
    COND_TARGET_OUTPUT_A,
    COND_IDLE,
    COND_WAIT
  } pss_cond_type;
  typedef enum logic [1:0] {
    WSRC_GLOBAL,
    WSRC_PREV,
    WSRC_DIRECT
  } pss_wsrc_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COND,
    ST_WAIT,
    ST_DONE
  } pss_state_type;
endpackage
`default_nettype wire

// ==== src/pss_step_mem.sv ====
/*
  Step table: five field arrays of 64 entries, registered read.
  Assumes writes only while no program runs.
*/
`default_nettype none
`include "pss_cfg.svh"
module pss_step_mem #(
  parameter int STEPS = 64
) (
  input wire logic SYS_CLK_I,
  pss_mem_if.mem m
);
  logic [31:0] tab_q [5][STEPS];

  // Table holds no reset; host fills it before a start
  always_ff @(posedge SYS_CLK_I) begin
    if (m.we && m.wsel < 3'h5) begin
      tab_q[m.wsel][m.waddr] <= m.wdata;
    end
    m.rwidth <= tab_q[0][m.raddr];
    m.rarea1 <= tab_q[1][m.raddr];
    m.rarea2 <= tab_q[2][m.raddr];
    m.revent <= tab_q[3][m.raddr];
    m.rnext <= tab_q[4][m.raddr];
  end
endmodule
`default_nettype wire

// ==== src/pss_top.sv ====
/*
  Program step sequencer: table writes over APB (table reads return zero), step completion and next-step choice.
  Assumes motion status inputs synchronous to SYS_CLK_I and a host that programs the table first.
*/
`default_nettype none
`include "pss_cfg.svh"
module pss_top #(
  parameter int CYC_PER_MS = `PSS_CYC_PER_MS
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic IN_POSITION_I,
  input wire logic TARGET_TARGET_OUTPUT_A_I,
  input wire logic MOTION_ACTIVE_I,
  output logic RUNNING_O,
  output logic [5:0] STEP_O,
  output logic STEP_DONE_O,
  output logic [26:0] STEP_WIDTH_O,
  output logic IN_AREA_O
);
  pss_mem_if mi();
  pss_step_mem #(.STEPS(64)) u_mem (.SYS_CLK_I(SYS_CLK_I), .m(mi));

  pss_pkg::pss_state_type st_q, st_d;
  logic [26:0] gwidth_q, gwidth_d;
  logic [5:0] tsel_q, tsel_d;
  logic [5:0] step_q, step_d;
  logic [5:0] start_q, start_d;
  logic [31:0] pos_q, pos_d;
  logic [26:0] width_q, width_d;
  logic [2:0] cond_q, cond_d;
  logic [16:0] ms_q, ms_d;
  logic [31:0] cyc_q, cyc_d;
  logic done_q, done_d;
  logic inarea_q, inarea_d;
  logic fetch_q, fetch_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic acc;
  logic wr;
  logic rd_ok;
  logic start_p;
  logic stop_p;
  logic cond_met;
  logic [2:0] ev_cond;
  logic ev_same;
  logic [16:0] ev_wait;
  logic [1:0] wsrc;
  logic [26:0] wval;
  logic [2:0] cond_use;

  assign acc = PSEL_I && PENABLE_I;
  assign wr = acc && PWRITE_I && !PREADY_O;
  assign start_p = wr && PADDR_I == `PSS_ADDR_CTRL && PWDATA_I[0];
  assign stop_p = wr && PADDR_I == `PSS_ADDR_CTRL && PWDATA_I[1];

  // Table write port; row chosen by table select register
  always_comb begin
    mi.we = 1'b0;
    mi.wsel = 3'h7;
    mi.waddr = tsel_q;
    mi.wdata = PWDATA_I;
    if (wr) begin
      if (PADDR_I == `PSS_ADDR_TWIDTH) begin
        mi.we = 1'b1;
        mi.wsel = 3'h0;
      end else if (PADDR_I == `PSS_ADDR_TAREA1) begin
        mi.we = 1'b1;
        mi.wsel = 3'h1;
      end else if (PADDR_I == `PSS_ADDR_TAREA2) begin
        mi.we = 1'b1;
        mi.wsel = 3'h2;
      end else if (PADDR_I == `PSS_ADDR_TEVENT) begin
        mi.we = 1'b1;
        mi.wsel = 3'h3;
      end else if (PADDR_I == `PSS_ADDR_TNEXT) begin
        mi.we = 1'b1;
        mi.wsel = 3'h4;
      end
    end
    // Row of the step in force after this edge, so the registered read lines up with the fetch cycle
    mi.raddr = step_d;
  end

  // Field decode of the current step row
  always_comb begin
    ev_cond = mi.revent[`PSS_EV_COND_LSB +: 3];
    ev_same = mi.revent[`PSS_EV_SAME_BIT];
    ev_wait = mi.revent[16:0];
    wsrc = mi.rwidth[`PSS_WD_SRC_LSB +: 2];
    // Out-of-range direct widths clamp to 1..99999999
    if (mi.rwidth[26:0] < `PSS_WIDTH_MIN) begin
      wval = `PSS_WIDTH_MIN;
    end else if (mi.rwidth[26:0] > `PSS_WIDTH_MAX) begin
      wval = `PSS_WIDTH_MAX;
    end else begin
      wval = mi.rwidth[26:0];
    end
    cond_use = ev_same ? cond_q : ev_cond;
  end

  // Condition selection from the motion status inputs
  always_comb begin
    case (cond_q)
      3'(pss_pkg::COND_IN_POS): cond_met = IN_POSITION_I;
      3'(pss_pkg::COND_TARGET_OUTPUT_A): cond_met = TARGET_TARGET_OUTPUT_A_I;
      3'(pss_pkg::COND_IDLE): cond_met = !MOTION_ACTIVE_I;
      default: cond_met = 1'b1;
    endcase
  end

  // Sequencer next state; fetch takes one cycle because table read is registered
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    width_d = width_q;
    cond_d = cond_q;
    ms_d = ms_q;
    cyc_d = cyc_q;
    done_d = 1'b0;
    fetch_d = 1'b0;
    case (st_q)
      pss_pkg::ST_IDLE: begin
        if (start_p) begin
          step_d = PWDATA_I[13:8];
          fetch_d = 1'b1;
          cond_d = 3'(pss_pkg::COND_IN_POS);
          width_d = `PSS_WIDTH_RST;
          st_d = pss_pkg::ST_COND;
        end
      end
      pss_pkg::ST_COND: begin
        if (fetch_q) begin
          if (wsrc == 2'(pss_pkg::WSRC_GLOBAL)) begin
            width_d = gwidth_q;
          end else if (wsrc == 2'(pss_pkg::WSRC_DIRECT)) begin
            width_d = wval;
          end
          cond_d = cond_use;
          ms_d = (ev_wait > `PSS_WAIT_MAX) ? `PSS_WAIT_MAX : ev_wait;
          cyc_d = 32'h0;
        end else if (cond_met) begin
          st_d = pss_pkg::ST_WAIT;
        end
      end
      pss_pkg::ST_WAIT: begin
        // Wait runs only after the condition has been seen
        if (ms_q == 17'h0) begin
          st_d = pss_pkg::ST_DONE;
        end else if (cyc_q == 32'(CYC_PER_MS - 1)) begin
          cyc_d = 32'h0;
          ms_d = ms_q - 17'h1;
        end else begin
          cyc_d = cyc_q + 32'h1;
        end
      end
      pss_pkg::ST_DONE: begin
        done_d = 1'b1;
        if (mi.rnext[`PSS_NX_END_BIT]) begin
          st_d = pss_pkg::ST_IDLE;
        end else begin
          step_d = mi.rnext[5:0];
          fetch_d = 1'b1;
          st_d = pss_pkg::ST_COND;
        end
      end
      default: st_d = pss_pkg::ST_IDLE;
    endcase
    if (stop_p) begin
      st_d = pss_pkg::ST_IDLE;
    end
  end

  // Area test on the signed bounds of the current step
  always_comb begin
    if ($signed(mi.rarea1) <= $signed(mi.rarea2)) begin
      inarea_d = ($signed(pos_q) >= $signed(mi.rarea1)) && ($signed(pos_q) <= $signed(mi.rarea2));
    end else begin
      inarea_d = 1'b0;
    end
  end

  // Register writes
  always_comb begin
    gwidth_d = gwidth_q;
    tsel_d = tsel_q;
    start_d = start_q;
    pos_d = pos_q;
    if (wr && PADDR_I == `PSS_ADDR_GWIDTH) begin
      if (PWDATA_I[26:0] == 27'h0) begin
        gwidth_d = `PSS_WIDTH_MIN;
      end else if (PWDATA_I[26:0] > `PSS_WIDTH_MAX) begin
        gwidth_d = `PSS_WIDTH_MAX;
      end else begin
        gwidth_d = PWDATA_I[26:0];
      end
    end
    if (wr && PADDR_I == `PSS_ADDR_TSEL) begin
      tsel_d = PWDATA_I[5:0];
    end
    if (wr && PADDR_I == `PSS_ADDR_CTRL) begin
      start_d = PWDATA_I[13:8];
    end
    if (wr && PADDR_I == `PSS_ADDR_POS) begin
      // Positions outside the signed range saturate
      if ($signed(PWDATA_I) > $signed(`PSS_POS_MAX)) begin
        pos_d = `PSS_POS_MAX;
      end else if ($signed(PWDATA_I) < $signed(`PSS_POS_MIN)) begin
        pos_d = `PSS_POS_MIN;
      end else begin
        pos_d = PWDATA_I;
      end
    end
  end

  // APB answer: one wait state, PREADY in the second access cycle
  always_comb begin
    pready_d = acc && !PREADY_O;
    pslverr_d = 1'b0;
    prdata_d = 32'h0;
    rd_ok = 1'b1;
    if (PADDR_I == `PSS_ADDR_CTRL) begin
      prdata_d = {18'h0, start_q, 8'h0};
    end else if (PADDR_I == `PSS_ADDR_STATUS) begin
      prdata_d = {21'h0, inarea_q, step_q, 2'h0, done_q, RUNNING_O};
    end else if (PADDR_I == `PSS_ADDR_GWIDTH) begin
      prdata_d = {5'h0, gwidth_q};
    end else if (PADDR_I == `PSS_ADDR_TSEL) begin
      prdata_d = {26'h0, tsel_q};
    end else if (PADDR_I == `PSS_ADDR_POS) begin
      prdata_d = pos_q;
    end else if (PADDR_I == `PSS_ADDR_TWIDTH || PADDR_I == `PSS_ADDR_TAREA1 ||
                 PADDR_I == `PSS_ADDR_TAREA2 || PADDR_I == `PSS_ADDR_TEVENT ||
                 PADDR_I == `PSS_ADDR_TNEXT) begin
      prdata_d = 32'h0;
    end else begin
      rd_ok = 1'b0;
    end
    if (!rd_ok && acc && !PREADY_O) begin
      pslverr_d = 1'b1;
    end
    if (!(acc && !PREADY_O && !PWRITE_I)) begin
      prdata_d = 32'h0;
    end
  end

  // State registers
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= pss_pkg::ST_IDLE;
      gwidth_q <= `PSS_WIDTH_RST;
      tsel_q <= 6'h0;
      start_q <= 6'h0;
      step_q <= 6'h0;
      pos_q <= `PSS_AREA_RST;
      width_q <= `PSS_WIDTH_RST;
      cond_q <= 3'(pss_pkg::COND_IN_POS);
      ms_q <= 17'h0;
      cyc_q <= 32'h0;
      done_q <= 1'b0;
      inarea_q <= 1'b0;
      fetch_q <= 1'b0;
      PRDATA_O <= 32'h0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      RUNNING_O <= 1'b0;
      STEP_O <= 6'h0;
      STEP_DONE_O <= 1'b0;
      STEP_WIDTH_O <= `PSS_WIDTH_RST;
      IN_AREA_O <= 1'b0;
    end else begin
      st_q <= st_d;
      gwidth_q <= gwidth_d;
      tsel_q <= tsel_d;
      start_q <= start_d;
      step_q <= step_d;
      pos_q <= pos_d;
      width_q <= width_d;
      cond_q <= cond_d;
      ms_q <= ms_d;
      cyc_q <= cyc_d;
      done_q <= done_d;
      inarea_q <= inarea_d;
      fetch_q <= fetch_d;
      PRDATA_O <= prdata_d;
      PREADY_O <= pready_d;
      PSLVERR_O <= pslverr_d;
      RUNNING_O <= st_d != pss_pkg::ST_IDLE;
      STEP_O <= step_d;
      STEP_DONE_O <= done_d;
      STEP_WIDTH_O <= width_d;
      IN_AREA_O <= inarea_d;
    end
  end

  property p_wait_zero_done;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_WAIT && ms_q == 17'h0 && !stop_p) |=> st_q == pss_pkg::ST_DONE;
  endproperty
  a_wait_zero_done: assert property (p_wait_zero_done) else $error("zero wait did not finish");

  property p_cond_gate;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_COND && !fetch_q && !cond_met) |=> st_q != pss_pkg::ST_WAIT;
  endproperty
  a_cond_gate: assert property (p_cond_gate) else $error("wait began before condition");

  property p_in_position;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_COND && !fetch_q && cond_q == 3'h0 && IN_POSITION_I && !stop_p)
      |=> st_q == pss_pkg::ST_WAIT;
  endproperty
  a_in_position: assert property (p_in_position) else $error("in-position did not end condition");

  property p_target_output_a;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_COND && !fetch_q && cond_q == 3'h1 && TARGET_TARGET_OUTPUT_A_I && !stop_p)
      |=> st_q == pss_pkg::ST_WAIT;
  endproperty
  a_target_output_a: assert property (p_target_output_a) else $error("target_output_a did not end condition");

  property p_idle;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_COND && cond_q == 3'h2 && MOTION_ACTIVE_I && !fetch_q) |=> st_q != pss_pkg::ST_WAIT;
  endproperty
  a_idle: assert property (p_idle) else $error("ended while motion active");

  property p_end;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_DONE && mi.rnext[6]) |=> !RUNNING_O;
  endproperty
  a_end: assert property (p_end) else $error("program did not end");

  property p_next;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_DONE && !mi.rnext[6] && !stop_p) |=> STEP_O == $past(mi.rnext[5:0]) && fetch_q;
  endproperty
  a_next: assert property (p_next) else $error("next step not taken");

  property p_width_range;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    STEP_WIDTH_O >= 27'h1 && STEP_WIDTH_O <= 27'h5f5e0ff;
  endproperty
  a_width_range: assert property (p_width_range) else $error("width out of range");

  property p_global;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_COND && fetch_q && wsrc == 2'h0) |=> STEP_WIDTH_O == $past(gwidth_q);
  endproperty
  a_global: assert property (p_global) else $error("global width not used");

  property p_pos_range;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    $signed(pos_q) <= $signed(32'h05f5e0ff) && $signed(pos_q) >= $signed(32'hfa0a1f01);
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("position out of range");

  property p_area;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ($signed(mi.rarea1) <= $signed(mi.rarea2) && pos_q == mi.rarea2) |=> IN_AREA_O;
  endproperty
  a_area: assert property (p_area) else $error("inclusive bound missed");

  property p_same;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_COND && fetch_q && ev_same) |=> cond_q == $past(cond_q);
  endproperty
  a_same: assert property (p_same) else $error("previous condition not kept");

  property p_waitonly;
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st_q == pss_pkg::ST_COND && !fetch_q && cond_q == 3'h3 && !stop_p) |=> st_q == pss_pkg::ST_WAIT;
  endproperty
  a_waitonly: assert property (p_waitonly) else $error("wait-only did not start wait");
endmodule
`default_nettype wire

// ==== verification/program_step_sequencer_tb.sv ====
/*
  Self-checking bench: APB table setup, a five-step program, area and stop checks.
  Assumes the design answers APB with wait states and CYC_PER_MS set to 2.
*/
`default_nettype none
`include "pss_cfg.svh"
module program_step_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic in_pos;
  logic target_output_a;
  logic moving;
  logic running;
  logic [5:0] step;
  logic step_done;
  logic [26:0] width;
  logic in_area;
  logic [31:0] rd;
  logic err;
  logic [7:0] cyc = 8'h00;
  int miscompares = 0;
  int compares = 0;
  int steps [5] = '{0, 1, 2, 3, 63};
  int widths [5] = '{20, 20, 12345, 1, 1};
  int lo [5] = '{64, 20, 40, 6, 6};
  always #10 clk = ~clk;
  pss_top #(.CYC_PER_MS(2)) uut (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IN_POSITION_I(in_pos), .TARGET_TARGET_OUTPUT_A_I(target_output_a), .MOTION_ACTIVE_I(moving),
    .RUNNING_O(running), .STEP_O(step), .STEP_DONE_O(step_done), .STEP_WIDTH_O(width),
    .IN_AREA_O(in_area));
  pss_motion_model #(.D(20)) model (.clk_i(clk), .rst_i(rst), .running_i(running),
    .step_done_i(step_done), .in_pos_o(in_pos), .target_output_a_o(target_output_a), .moving_o(moving));
  // Cycles since the current step began, same basis as the model's profile
  always @(posedge clk) begin
    cyc <= (!running || step_done) ? 8'h00 : cyc + 8'h01;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic row(input logic [5:0] r, input logic [31:0] wd, a1, a2, ev, nx);
    apb(1'b1, `PSS_ADDR_TSEL, {26'h0, r});
    apb(1'b1, `PSS_ADDR_TWIDTH, wd);
    apb(1'b1, `PSS_ADDR_TAREA1, a1);
    apb(1'b1, `PSS_ADDR_TAREA2, a2);
    apb(1'b1, `PSS_ADDR_TEVENT, ev);
    apb(1'b1, `PSS_ADDR_TNEXT, nx);
  endtask
  task automatic wait_for(input logic [7:0] c);
    int n;
    for (n = 0; n < 300 && !(running === 1'b1 && cyc === c); n++) begin
      @(posedge clk);
    end
  endtask
  task automatic pos_area(input logic [31:0] p, input logic exp);
    apb(1'b1, `PSS_ADDR_POS, p);
    repeat (3) @(posedge clk);
    check("in_area", {31'h0, in_area}, {31'h0, exp});
  endtask
  initial begin
    #(20 * 3000);
    miscompares++;
    conclude();
  end
  initial begin
    int k;
    int n;
    repeat (20) @(posedge clk);
    check("width_rst", {5'h0, width}, 32'h0000000a);
    check("run_rst", {31'h0, running}, 32'h00000000);
    rst <= 1'b0;
    apb(1'b0, `PSS_ADDR_GWIDTH, 32'h0);
    check("gwidth_rst", rd, 32'h0000000a);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", {31'h0, err}, 32'h00000001);
    apb(1'b1, `PSS_ADDR_GWIDTH, 32'h00000014);
    // Width source in bits 28:27, condition 19:17, same flag 20, end flag 6
    row(6'h00, 32'h00000000, 32'hfffffffb, 32'h00000005, 32'h00000002, 32'h00000001);
    row(6'h01, 32'h08000000, 32'h00000003, 32'hfffffffd, 32'h00020000, 32'h00000002);
    row(6'h02, 32'h10003039, 32'h0, 32'h0, 32'h00040000, 32'h00000003);
    row(6'h03, 32'h10000000, 32'h0, 32'h0, 32'h00060003, 32'h0000003f);
    row(6'h3f, 32'h08000000, 32'h0, 32'h0, 32'h00100003, 32'h00000040);
    apb(1'b1, `PSS_ADDR_POS, 32'h00000005);
    apb(1'b1, `PSS_ADDR_CTRL, 32'h00000001);
    for (k = 0; k < 5; k++) begin
      wait_for(8'h05);
      check("step", {26'h0, step}, steps[k]);
      check("width", {5'h0, width}, widths[k]);
      if (k == 0) begin
        check("in_area", {31'h0, in_area}, 32'h00000001);
        pos_area(32'h00000006, 1'b0);
        pos_area(32'hfffffffb, 1'b1);
        pos_area(32'hfffffffa, 1'b0);
        apb(1'b1, `PSS_ADDR_POS, 32'h00000000);
      end
      if (k == 1) begin
        check("in_area_swapped", {31'h0, in_area}, 32'h00000000);
      end
      for (n = 0; n < 200 && step_done !== 1'b1; n++) begin
        @(posedge clk);
      end
      check("done_seen", {31'h0, step_done}, 32'h00000001);
      check("early", {31'h0, (cyc >= lo[k])}, 32'h00000001);
      check("late", {31'h0, (cyc <= lo[k] + 8)}, 32'h00000001);
      @(posedge clk);
    end
    check("ended", {31'h0, running}, 32'h00000000);
    // Restart at a chosen step given in the same write as the start bit
    apb(1'b1, `PSS_ADDR_CTRL, 32'h00000301);
    wait_for(8'h05);
    check("restart", {31'h0, running}, 32'h00000001);
    check("restart_step", {26'h0, step}, 32'h00000003);
    apb(1'b1, `PSS_ADDR_CTRL, 32'h00000002);
    repeat (3) @(posedge clk);
    check("stopped", {31'h0, running}, 32'h00000000);
    conclude();
  end
endmodule
`default_nettype wire

// ==== verification/pss_motion_model.sv ====
/*
  Motion profile generator stand-in: status outputs follow a fixed profile per step.
  Assumes the sequencer's running level and step-done pulse on the same clock.
*/
`default_nettype none
module pss_motion_model #(
  parameter int D = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic running_i,
  input wire logic step_done_i,
  output logic in_pos_o,
  output logic target_output_a_o,
  output logic moving_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  // Profile restarts on every step; saturates so the outputs stay put
  always_comb begin
    cnt_d = cnt_q;
    if (!running_i || step_done_i) begin
      cnt_d = 8'h00;
    end else if (cnt_q != 8'hff) begin
      cnt_d = cnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // Target_output_a first, then motion stops, then in position: each condition has its own time
  assign target_output_a_o = running_i && (cnt_q >= 8'(D));
  assign moving_o = running_i && (cnt_q < 8'(2 * D));
  assign in_pos_o = running_i && (cnt_q >= 8'(3 * D));
endmodule
`default_nettype wire
